/* design/tcci_consts.svh */
// Named offsets, slots, bit positions and reset values of the transmit channel code insertion block
`ifndef TCCI_CONSTS_SVH
`define TCCI_CONSTS_SVH

// Per-port register indexes, byte address is four times the index
`define TCCI_IDX_JAM1       9'h104
`define TCCI_IDX_JAM2       9'h105
`define TCCI_IDX_JAM3       9'h106
`define TCCI_IDX_JAM4       9'h107
`define TCCI_IDX_DDS1       9'h108
`define TCCI_IDX_DDS2       9'h109
`define TCCI_IDX_DDS3       9'h10a
`define TCCI_IDX_IDLE1      9'h150
`define TCCI_IDX_IDLE2      9'h151
`define TCCI_IDX_IDLE3      9'h152
`define TCCI_IDX_IDLE4      9'h153
`define TCCI_IDX_CTL4       9'h1f4
`define TCCI_IDX_CTL2       9'h1f5
`define TCCI_IDX_JAMCODE    9'h1f6
`define TCCI_IDX_DDSCODE    9'h1f7
`define TCCI_IDX_IDLECODE   9'h1f8

// Port number sits above the 0x200-index stride
`define TCCI_PORT_LSB       9
`define TCCI_PORT_MSB       11
`define TCCI_IDX_MSB        13
`define TCCI_ADDR_HI_ZERO   2'h0

// Storage slots inside one port's bank
`define TCCI_SLOT_JAM1      4'h0
`define TCCI_SLOT_DDS1      4'h4
`define TCCI_SLOT_IDLE1     4'h7
`define TCCI_SLOT_CTL4      4'hb
`define TCCI_SLOT_CTL2      4'hc
`define TCCI_SLOT_JAMCODE   4'hd
`define TCCI_SLOT_DDSCODE   4'he
`define TCCI_SLOT_IDLECODE  4'hf

// Control bit positions
`define TCCI_CTL4_JAM_EN    0
`define TCCI_CTL4_E1_MODE   1
`define TCCI_CTL2_DDS_EN    0

// Reset values
`define TCCI_RST_SEL        8'h00
`define TCCI_RST_JAMCODE    8'h01
`define TCCI_RST_DDSCODE    8'h01
`define TCCI_RST_IDLECODE   8'hff

// Stream and bus constants
`define TCCI_T1_CHANS       5'h18
`define TCCI_ZERO_BYTE      8'h00
`define TCCI_RESP_OKAY      2'h0
`define TCCI_RESP_SLVERR    2'h2
`define TCCI_FIFO_DEPTH     8
`define TCCI_BANK_WORDS     128

`endif

/* design/tcci_pkg.sv */
// Types shared by the transmit channel code insertion block
package tcci_pkg;

  // One channel time slot of the transmit stream
  typedef struct packed {
    logic [2:0] port;   // Port 0..7 stands for port 1..8
    logic [4:0] chan;   // Channel 0..31 stands for channel 1..32
    logic [7:0] data;   // Channel byte
  } tcci_slot_s;

  // Register byte
  typedef logic [7:0] tcci_byte_t;

endpackage : tcci_pkg

/* design/tcci_fifo.sv */
// Parameterised synchronous FIFO with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none

module tcci_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [0:DEPTH-1];  // Storage words
  logic [PW-1:0]    wr_ptr;           // Next word to fill
  logic [PW-1:0]    rd_ptr;           // Oldest word
  logic [PW:0]      count;            // Words held
  wire              push;             // Word taken on fill side
  wire              pop;              // Word leaves on drain side

  // Honest flags straight from the count
  assign in_ready  = (count != (PW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage write, no reset needed for data
  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
      end
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // Never overfill or underflow
  a_fifo_bounds : assert property (@(posedge aclk) disable iff (!aresetn)
    count <= (PW+1)'(DEPTH)) else $error("fifo count above depth");

endmodule : tcci_fifo

`default_nettype wire

/* design/tcci_top.sv */
// Transmit channel code insertion for eight ports with AXI4-Lite registers
//
// Contract
// - Idle-enabled channel gets its programmed idle code
// - Enable bit 1 inserts, 0 passes data
// - 24 channels in T1, 32 in E1
// - Register j bit k drives channel 8(j-1)+k+1
// - Jam stuffing only when selected and globally enabled
// - Selected all-zero byte becomes jam stuffing code
// - Zero-code stuffing: T1 channels 1-24, global enable
// - Eight port copies, stride 0x200 indexes
// - Selected all-zero byte becomes zero-code pattern
`timescale 1ns/100ps
`default_nettype none
`include "tcci_consts.svh"

module tcci_top
  import tcci_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [15:0] s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [15:0] s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Backplane transmit stream in
  input  wire logic        tx_in_valid,
  output logic             tx_in_ready,
  input  wire tcci_slot_s  tx_in,
  // Line-side transmit stream out
  output logic             tx_out_valid,
  input  wire logic        tx_out_ready,
  output tcci_slot_s       tx_out
);

  // Map a per-port index onto a storage slot, top bit flags a hit
  function automatic logic [4:0] tcci_slot_of(input logic [8:0] loc);
    logic [4:0] r;
    r = 5'h00;
    case (loc)
      `TCCI_IDX_JAM1:     r = {1'b1, `TCCI_SLOT_JAM1};
      `TCCI_IDX_JAM2:     r = {1'b1, `TCCI_SLOT_JAM1 + 4'h1};
      `TCCI_IDX_JAM3:     r = {1'b1, `TCCI_SLOT_JAM1 + 4'h2};
      `TCCI_IDX_JAM4:     r = {1'b1, `TCCI_SLOT_JAM1 + 4'h3};
      `TCCI_IDX_DDS1:     r = {1'b1, `TCCI_SLOT_DDS1};
      `TCCI_IDX_DDS2:     r = {1'b1, `TCCI_SLOT_DDS1 + 4'h1};
      `TCCI_IDX_DDS3:     r = {1'b1, `TCCI_SLOT_DDS1 + 4'h2};
      `TCCI_IDX_IDLE1:    r = {1'b1, `TCCI_SLOT_IDLE1};
      `TCCI_IDX_IDLE2:    r = {1'b1, `TCCI_SLOT_IDLE1 + 4'h1};
      `TCCI_IDX_IDLE3:    r = {1'b1, `TCCI_SLOT_IDLE1 + 4'h2};
      `TCCI_IDX_IDLE4:    r = {1'b1, `TCCI_SLOT_IDLE1 + 4'h3};
      `TCCI_IDX_CTL4:     r = {1'b1, `TCCI_SLOT_CTL4};
      `TCCI_IDX_CTL2:     r = {1'b1, `TCCI_SLOT_CTL2};
      `TCCI_IDX_JAMCODE:  r = {1'b1, `TCCI_SLOT_JAMCODE};
      `TCCI_IDX_DDSCODE:  r = {1'b1, `TCCI_SLOT_DDSCODE};
      `TCCI_IDX_IDLECODE: r = {1'b1, `TCCI_SLOT_IDLECODE};
      default:            r = 5'h00;
    endcase
    return r;
  endfunction : tcci_slot_of

  // Reset value of each storage slot
  function automatic tcci_byte_t tcci_rst_of(input logic [3:0] slot);
    tcci_byte_t v;
    v = `TCCI_RST_SEL;
    case (slot)
      `TCCI_SLOT_JAMCODE:  v = `TCCI_RST_JAMCODE;
      `TCCI_SLOT_DDSCODE:  v = `TCCI_RST_DDSCODE;
      `TCCI_SLOT_IDLECODE: v = `TCCI_RST_IDLECODE;
      default:             v = `TCCI_RST_SEL;
    endcase
    return v;
  endfunction : tcci_rst_of

  // Register bank: sixteen slots per port, port number on top
  tcci_byte_t  bank [0:`TCCI_BANK_WORDS-1];

  // Write channel state
  logic        aw_held;      // Write address captured
  logic        w_held;       // Write data captured
  logic [15:0] aw_addr;      // Captured write address
  tcci_byte_t  w_byte;       // Captured low byte
  logic        w_lane0;      // Low byte lane strobed

  // Write decode
  wire  [4:0]  wr_map    = tcci_slot_of(aw_addr[`TCCI_PORT_LSB+1:2]);
  wire  [2:0]  wr_port   = aw_addr[`TCCI_IDX_MSB:`TCCI_PORT_LSB+2];
  wire         wr_ok     = wr_map[4] && (aw_addr[15:14] == `TCCI_ADDR_HI_ZERO);
  wire  [6:0]  wr_ix     = {wr_port, wr_map[3:0]};
  wire         wr_fire   = aw_held && w_held && !s_axi_bvalid;

  // Read decode
  wire  [4:0]  rd_map    = tcci_slot_of(s_axi_araddr[`TCCI_PORT_LSB+1:2]);
  wire  [2:0]  rd_port   = s_axi_araddr[`TCCI_IDX_MSB:`TCCI_PORT_LSB+2];
  wire         rd_ok     = rd_map[4] && (s_axi_araddr[15:14] == `TCCI_ADDR_HI_ZERO);
  wire  [6:0]  rd_ix     = {rd_port, rd_map[3:0]};
  wire         rd_take   = s_axi_arvalid && s_axi_arready;

  // A channel takes one item at a time and stalls while a response waits
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // Capture write address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 16'h0000;
      w_byte  <= 8'h00;
      w_lane0 <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held  <= 1'b1;
        w_byte  <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response; unmapped addresses answer SLVERR and store nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `TCCI_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? `TCCI_RESP_OKAY : `TCCI_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Bank store; each port owns its own slots
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < `TCCI_BANK_WORDS; i++) begin
        bank[i] <= tcci_rst_of(4'(i));
      end
    end else if (wr_fire && wr_ok && w_lane0) begin
      bank[wr_ix] <= w_byte;
    end
  end

  // Read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `TCCI_RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_ok ? {24'h00_0000, bank[rd_ix]} : 32'h0000_0000;
      s_axi_rresp  <= rd_ok ? `TCCI_RESP_OKAY : `TCCI_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Slot FIFO between backplane and substitution stage
  wire         head_valid;   // FIFO holds a slot
  wire         head_ready;   // Substitution stage can take it
  wire  [15:0] head_bits;    // Raw FIFO word
  tcci_slot_s  head;         // Oldest slot

  tcci_fifo #(
    .WIDTH ($bits(tcci_slot_s)),
    .DEPTH (`TCCI_FIFO_DEPTH)
  ) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (tx_in_valid),
    .in_ready  (tx_in_ready),
    .in_data   (tx_in),
    .out_valid (head_valid),
    .out_ready (head_ready),
    .out_data  (head_bits)
  );

  assign head = tcci_slot_s'(head_bits);

  // Per-port settings for the head slot, read at the moment it leaves
  wire  [6:0]  pbase     = {head.port, 4'h0};
  wire  [2:0]  cbit      = head.chan[2:0];
  wire  [3:0]  idle_slot = `TCCI_SLOT_IDLE1 + {2'b00, head.chan[4:3]};
  wire  [3:0]  jam_slot  = `TCCI_SLOT_JAM1 + {2'b00, head.chan[4:3]};
  wire  [3:0]  dds_slot  = `TCCI_SLOT_DDS1 + {2'b00, head.chan[4:3]};
  wire  [7:0]  ctl4      = bank[pbase | {3'b000, `TCCI_SLOT_CTL4}];
  wire  [7:0]  ctl2      = bank[pbase | {3'b000, `TCCI_SLOT_CTL2}];
  wire  [7:0]  jam_code  = bank[pbase | {3'b000, `TCCI_SLOT_JAMCODE}];
  wire  [7:0]  dds_code  = bank[pbase | {3'b000, `TCCI_SLOT_DDSCODE}];
  wire  [7:0]  idle_code = bank[pbase | {3'b000, `TCCI_SLOT_IDLECODE}];
  wire         idle_bit  = bank[pbase | {3'b000, idle_slot}][cbit];
  wire         jam_bit   = bank[pbase | {3'b000, jam_slot}][cbit];
  wire         dds_bit   = bank[pbase | {3'b000, dds_slot}][cbit];

  // Mode and range; in T1 the fourth group is ignored
  wire         e1_mode   = ctl4[`TCCI_CTL4_E1_MODE];
  wire         t1_chan   = (head.chan < `TCCI_T1_CHANS);
  wire         in_range  = e1_mode || t1_chan;
  wire         zero_byte = (head.data == `TCCI_ZERO_BYTE);

  // Substitution choices for this slot
  wire         idle_hit  = in_range && idle_bit;
  wire         jam_hit   = ctl4[`TCCI_CTL4_JAM_EN] && in_range && jam_bit && zero_byte;
  wire         dds_hit   = !e1_mode && ctl2[`TCCI_CTL2_DDS_EN] && t1_chan && dds_bit && zero_byte;

  // Idle first, then jam, then zero code, else untouched
  wire  [7:0]  next_data = idle_hit ? idle_code :
                           jam_hit  ? jam_code  :
                           dds_hit  ? dds_code  : head.data;

  // Stage refills whenever empty or being drained
  assign head_ready = !tx_out_valid || tx_out_ready;
  wire         take_slot = head_valid && head_ready;

  // Output register; decided per slot as it leaves the FIFO, so a new setting is seen by the next slot
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_out_valid <= 1'b0;
      tx_out       <= '0;
    end else if (head_ready) begin
      tx_out_valid <= head_valid;
      if (head_valid) begin
        tx_out <= '{port: head.port, chan: head.chan, data: next_data};
      end
    end
  end

  // Named steps of a register write and of a slot leaving the FIFO
  sequence s_write_fire;
    wr_fire && wr_ok && w_lane0;
  endsequence

  sequence s_take;
    take_slot;
  endsequence

  a_idle_insert : assert property (@(posedge aclk) disable iff (!aresetn)
    s_take ##0 idle_hit |=> tx_out.data == $past(idle_code)) else $error("idle code not inserted");

  a_idle_off_pass : assert property (@(posedge aclk) disable iff (!aresetn)
    s_take ##0 (!idle_bit && !zero_byte) |=> tx_out.data == $past(head.data)) else $error("data changed");

  a_t1_range : assert property (@(posedge aclk) disable iff (!aresetn)
    s_take ##0 (!e1_mode && !t1_chan) |=> tx_out.data == $past(head.data)) else $error("T1 slot 25+ changed");

  a_bit_map : assert property (@(posedge aclk) disable iff (!aresetn)
    s_take ##0 (in_range && bank[pbase | 7'(`TCCI_SLOT_IDLE1 + 4'h1)][0] && head.chan == 5'h08)
    |=> tx_out.data == $past(idle_code)) else $error("channel 9 not mapped to bit 0 of group 2");

  a_jam_gate : assert property (@(posedge aclk) disable iff (!aresetn)
    s_take ##0 (!ctl4[`TCCI_CTL4_JAM_EN] && !idle_hit && !dds_hit) |=> tx_out.data == $past(head.data))
    else $error("jam stuffing while disabled");

  a_jam_stuff : assert property (@(posedge aclk) disable iff (!aresetn)
    s_take ##0 (jam_hit && !idle_hit) |=> tx_out.data == $past(jam_code)) else $error("jam code missing");

  a_dds_t1_only : assert property (@(posedge aclk) disable iff (!aresetn)
    s_take ##0 (e1_mode && !idle_hit && !jam_hit) |=> tx_out.data == $past(head.data))
    else $error("zero code used in E1");

  a_dds_stuff : assert property (@(posedge aclk) disable iff (!aresetn)
    s_take ##0 (dds_hit && !idle_hit && !jam_hit) |=> tx_out.data == $past(dds_code))
    else $error("zero code missing");

  a_port_copy : assert property (@(posedge aclk) disable iff (!aresetn)
    s_write_fire |=> (bank[$past(wr_ix)] == $past(w_byte)) && s_axi_bvalid)
    else $error("port copy not written");

  a_idle_first : assert property (@(posedge aclk) disable iff (!aresetn)
    s_take ##0 (idle_hit && (jam_hit || dds_hit)) |=> tx_out.data == $past(idle_code))
    else $error("stuffing beat idle");

  a_out_hold : assert property (@(posedge aclk) disable iff (!aresetn)
    (tx_out_valid && !tx_out_ready) |=> $stable(tx_out) && tx_out_valid) else $error("output dropped");

  a_bresp_follow : assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire |=> s_axi_bvalid) else $error("no write response");

endmodule : tcci_top

`default_nettype wire

/* testbench/tcci_bp_src.sv */
// Backplane source model that feeds transmit channel slots into the block
`timescale 1ns/100ps
`default_nettype none

module tcci_bp_src
  import tcci_pkg::*;
(
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Slot stream towards the block
  output var  logic       valid,
  input  wire logic       ready,
  output var  tcci_slot_s slot
);
  tcci_slot_s q[$];  // Slots waiting to be offered

  // Queue one slot for sending
  task automatic push(input tcci_slot_s s);
    q.push_back(s);
  endtask : push

  // Offer the head slot and hold it until taken; random gaps make the source slow at times
  always @(posedge aclk) begin
    if (!aresetn) begin
      valid <= 1'b0;
      slot  <= '0;
    end else if (!valid || ready) begin
      if (q.size() != 0 && $urandom_range(3) != 0) begin
        valid <= 1'b1;
        slot  <= q.pop_front();
      end else begin
        // Released lines toggle so a stale slot never passes for a fresh one
        valid <= 1'b0;
        slot  <= ~slot;
      end
    end
  end

endmodule : tcci_bp_src

`default_nettype wire

/* testbench/tx_channel_code_insertion_bench.sv */
// Self-checking bench for transmit channel code insertion
`timescale 1ns/100ps
`default_nettype none
`include "tcci_consts.svh"

module tx_channel_code_insertion_bench
  import tcci_pkg::*;
;
  // Bus, stream and bench state
  logic        aclk, aresetn, awv, awr, wv, wr_rdy, bv, br, arv, arr, rv, rr, iv, ir, ov, orr, stall;
  logic [15:0] awa, ara;
  logic [31:0] wd, rdat;
  logic [3:0]  ws;
  logic [1:0]  bresp, rresp;
  tcci_slot_s  islot, oslot;
  int          rg [8][512];  // Register image per port, indexed by register index
  tcci_slot_s  exp_q[$];     // Expected line-side slots in order
  int          errors, n_checks, cyc, acc, a0;
  localparam int LIMIT = 40000;  // Whole run needs well under this
  localparam int IX[16] = '{`TCCI_IDX_JAM1, `TCCI_IDX_JAM2, `TCCI_IDX_JAM3, `TCCI_IDX_JAM4,
    `TCCI_IDX_DDS1, `TCCI_IDX_DDS2, `TCCI_IDX_DDS3, `TCCI_IDX_IDLE1, `TCCI_IDX_IDLE2,
    `TCCI_IDX_IDLE3, `TCCI_IDX_IDLE4, `TCCI_IDX_CTL4, `TCCI_IDX_CTL2, `TCCI_IDX_JAMCODE,
    `TCCI_IDX_DDSCODE, `TCCI_IDX_IDLECODE};

  tcci_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .s_axi_rdata(rdat), .s_axi_rresp(rresp), .tx_in_valid(iv), .tx_in_ready(ir), .tx_in(islot),
    .tx_out_valid(ov), .tx_out_ready(orr), .tx_out(oslot));

  tcci_bp_src src (.aclk(aclk), .aresetn(aresetn), .valid(iv), .ready(ir), .slot(islot));

  // Free-running 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Value comparison, counted
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  // Slot comparison
  task automatic cmp_slot(input tcci_slot_s e, input tcci_slot_s g);
    cmp("line slot", {16'h0, e}, {16'h0, g});
  endtask : cmp_slot

  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out

  // Byte address of a register index in one port's bank
  function automatic logic [15:0] addr(input int p, input int ix);
    return 16'(ix * 4 + p * 'h800);
  endfunction : addr

  // One register bit for zero-based channel c
  function automatic bit sel(input int p, input int base, input int c);
    return bit'((rg[p][base + c / 8] >> (c % 8)) & 1);
  endfunction : sel

  // Reference substitution; idle first, then jam, then zero code
  function automatic tcci_slot_s model(input tcci_slot_s s);
    int p, c;
    bit e1, inr;
    tcci_slot_s o;
    p = s.port;
    c = s.chan;
    o = s;
    e1 = rg[p][`TCCI_IDX_CTL4][`TCCI_CTL4_E1_MODE];
    inr = e1 || c < 24;
    if (inr && sel(p, `TCCI_IDX_IDLE1, c))
      o.data = 8'(rg[p][`TCCI_IDX_IDLECODE]);
    else if (rg[p][`TCCI_IDX_CTL4][0] && inr && sel(p, `TCCI_IDX_JAM1, c) && s.data == 0)
      o.data = 8'(rg[p][`TCCI_IDX_JAMCODE]);
    else if (!e1 && rg[p][`TCCI_IDX_CTL2][0] && c < 24 && sel(p, `TCCI_IDX_DDS1, c) && s.data == 0)
      o.data = 8'(rg[p][`TCCI_IDX_DDSCODE]);
    return o;
  endfunction : model

  // AXI4-Lite write: address and data offered together, each released when taken
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] er);
    bit pa, pw;
    pa = 1;
    pw = 1;
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= {24'h0, d};
    ws <= s;
    while (pa || pw) begin
      @(posedge aclk);
      if (pa && awr === 1'b1) begin
        pa = 0;
        awv <= 1'b0;
      end
      if (pw && wr_rdy === 1'b1) begin
        pw = 0;
        wv <= 1'b0;
      end
    end
    br <= 1'b1;
    do @(posedge aclk); while (bv !== 1'b1);
    br <= 1'b0;
    cmp("bresp", {30'h0, er}, {30'h0, bresp});
  endtask : wr

  // AXI4-Lite read with expected data and response
  task automatic rd(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
    arv <= 1'b1;
    ara <= a;
    do @(posedge aclk); while (arr !== 1'b1);
    arv <= 1'b0;
    rr <= 1'b1;
    do @(posedge aclk); while (rv !== 1'b1);
    rr <= 1'b0;
    cmp("rdata", ed, rdat);
    cmp("rresp", {30'h0, er}, {30'h0, rresp});
  endtask : rd

  // Write one register and keep the image in step
  task automatic wreg(input int p, input int ix, input int d);
    wr(addr(p, ix), 8'(d), 4'h1, `TCCI_RESP_OKAY);
    rg[p][ix] = d & 'hff;
  endtask : wreg

  // Read back every register of every port
  task automatic rdall();
    for (int p = 0; p < 8; p++)
      for (int k = 0; k < 16; k++)
        rd(addr(p, IX[k]), rg[p][IX[k]], `TCCI_RESP_OKAY);
  endtask : rdall

  // Queue a slot at the source and its expected result
  task automatic send(input int p, input int c, input int d);
    tcci_slot_s s;
    s = {3'(p), 5'(c), 8'(d)};
    exp_q.push_back(model(s));
    src.push(s);
  endtask : send

  // Wait until every expected slot has come out
  task automatic drain();
    for (int t = 0; t < 4000 && exp_q.size() != 0; t++)
      @(posedge aclk);
    cmp("slots left", 0, exp_q.size());
  endtask : drain

  // Line-side sink with random stalls, output checker and cycle limit
  always @(posedge aclk) begin
    orr <= !stall && $urandom_range(3) != 0;
    if (aresetn && ov === 1'b1 && orr) begin
      if (exp_q.size() == 0)
        cmp("unexpected slot", 0, 1);
      else
        cmp_slot(exp_q.pop_front(), oslot);
    end
    if (aresetn && iv && ir === 1'b1)
      acc++;
    cyc++;
    if (cyc == LIMIT) begin
      errors++;
      close_out();
    end
  end

  // Main sequence
  initial begin
    {awv, wv, br, arv, rr, stall} = '0;
    {awa, ara, wd, ws} = '0;
    aresetn = 1'b0;
    void'($urandom(52694));
    foreach (rg[p]) begin
      foreach (rg[p][i])
        rg[p][i] = 0;
      rg[p][`TCCI_IDX_JAMCODE] = `TCCI_RST_JAMCODE;
      rg[p][`TCCI_IDX_DDSCODE] = `TCCI_RST_DDSCODE;
      rg[p][`TCCI_IDX_IDLECODE] = `TCCI_RST_IDLECODE;
    end
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Reset values, unmapped places and a write without strobe
    cmp("out valid", 0, ov);
    rdall();
    rd(16'h0000, 0, `TCCI_RESP_SLVERR);
    wr(16'hc540, 8'h5a, 4'h1, `TCCI_RESP_SLVERR);
    rd(16'hc540, 0, `TCCI_RESP_SLVERR);
    wr(addr(0, `TCCI_IDX_IDLECODE), 8'h00, 4'h0, `TCCI_RESP_OKAY);
    rd(addr(0, `TCCI_IDX_IDLECODE), rg[0][`TCCI_IDX_IDLECODE], `TCCI_RESP_OKAY);
    $display("test reset done");
    // Random settings per port, every channel of every port, then readback
    for (int r = 0; r < 3; r++) begin
      for (int p = 0; p < 8; p++)
        for (int k = 0; k < 16; k++)
          wreg(p, IX[k], $urandom_range(255));
      for (int p = 0; p < 8; p++)
        for (int c = 0; c < 32; c++)
          send(p, c, $urandom_range(1) ? 0 : $urandom_range(255));
      drain();
      rdall();
      $display("test round %0d done", r);
    end
    // Fill the buffer with the line stalled, then drain it
    stall <= 1'b1;
    @(posedge aclk);
    a0 = acc;
    for (int c = 0; c < 12; c++)
      send(0, c, 0);
    repeat (40) @(posedge aclk);
    cmp("slots taken", `TCCI_FIFO_DEPTH + 1, acc - a0);
    cmp("in ready", 0, ir);
    stall <= 1'b0;
    drain();
    $display("test fill done");
    close_out();
  end

endmodule : tx_channel_code_insertion_bench

`default_nettype wire
